/* fault_cfg_pkg.sv */
// package with register map, field layout and timing constants
package fault_cfg_pkg;
    // ==========================================
    // register map
    localparam logic [7:0] fault_config_one_addr = 8'h92;
    localparam logic [31:0] fault_config_one_reset = 32'h0000_0000;
    // ==========================================
    // field positions
    localparam int deg_lsb = 27;
    localparam int deg_msb = 29;
    localparam int mode_lsb = 23;
    localparam int mode_msb = 26;
    localparam int lock_lsb = 19;
    localparam int lock_msb = 22;
    localparam int retry_lsb = 8;
    localparam int retry_msb = 10;
    // ==========================================
    // limit mode encodings
    typedef enum logic [3:0] {
        mode_next_pwm_flt = 4'h0,
        mode_next_pwm = 4'h1,
        mode_below_flt = 4'h2,
        mode_below = 4'h3,
        mode_retry_flt = 4'h4,
        mode_retry = 4'h5,
        mode_report = 4'h6
    } limit_mode_t;
    // ==========================================
    // deglitch times in ms and clock rate
    localparam int clk_hz = 40_000_000;
    localparam int deg_ms_0 = 1;
    localparam int deg_ms_1 = 10;
    localparam int deg_ms_2 = 25;
    localparam int deg_ms_3 = 50;
    localparam int deg_ms_4 = 100;
    localparam int deg_ms_5 = 250;
    localparam int deg_ms_6 = 500;
    localparam int deg_ms_7 = 1000;
    localparam int cycles_per_ms = clk_hz / 1000;
endpackage : fault_cfg_pkg

/* fault_config_current_limit.sv */
// fault configuration register with current-limit response logic
//
// Contract
// RULE1 - A 32-bit register at address 92h resets to all zeros.
// RULE2 - Bits 29-27 pick the no-motor deglitch time of 1 to 1000 ms.
// RULE3 - Modes 0h/1h recirculate, resume next PWM cycle, fault pin on 0h.
// RULE4 - High-side modes 2h/3h recirculate until phase drop, fault on 2h.
// RULE5 - Modes 4h/5h resume after the retry PWM count, fault pin on 4h.
// RULE6 - Mode 6h only reports an overcurrent and leaves the bridge alone.
// RULE7 - Modes 7h to Fh disable cycle-by-cycle limiting.
// RULE8 - Lock threshold is the bits 22-19 value divided by sense gain.
// RULE9 - Reserved bits store and read back as written and steer nothing.
`timescale 1ns/1ps
module fault_config_current_limit
    import fault_cfg_pkg::*;
#(
    parameter int cyc_per_ms = cycles_per_ms
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // drive status inputs (asynchronous)
    input wire logic overcurrent,
    input wire logic phase_sense_voltage_high,
    input wire logic pwm_cycle_start,
    input wire logic high_side_mod,
    input wire logic no_motor_raw,
    input wire logic [3:0] sense_amp_gain,
    // outputs
    output logic recirculate,
    output logic limit_report,
    output logic fault_indicator_n,
    output logic no_motor,
    output logic [3:0] lock_limit_code,
    output logic [3:0] lock_gain
);
    // ==========================================
    // input synchronisers
    logic [1:0] oc_s, vs_s, pw_s, hs_s, nm_s;
    logic pw_d;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            oc_s <= 2'b00;
            vs_s <= 2'b00;
            pw_s <= 2'b00;
            hs_s <= 2'b00;
            nm_s <= 2'b00;
            pw_d <= 1'b0;
        end else begin
            oc_s <= {oc_s[0], overcurrent};
            vs_s <= {vs_s[0], phase_sense_voltage_high};
            pw_s <= {pw_s[0], pwm_cycle_start};
            hs_s <= {hs_s[0], high_side_mod};
            nm_s <= {nm_s[0], no_motor_raw};
            pw_d <= pw_s[1];
        end
    end
    logic oc, vs, pwm_edge, hs;
    assign oc = oc_s[1];
    assign vs = vs_s[1];
    assign hs = hs_s[1];
    assign pwm_edge = pw_s[1] & ~pw_d;

    // ==========================================
    // register
    logic [31:0] fault_config_one;
    logic [31:0] next_cfg;
    always_comb begin
        next_cfg = fault_config_one;
        if (reg_write && reg_addr == fault_config_one_addr) begin
            next_cfg = reg_wdata; // whole word kept [RULE9]
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_config_one <= fault_config_one_reset; // [RULE1]
            reg_rdata <= fault_config_one_reset;
        end else begin
            fault_config_one <= next_cfg;
            reg_rdata <= (reg_addr == fault_config_one_addr) ?
                fault_config_one : 32'h0000_0000;
        end
    end

    logic [3:0] mode;
    logic [2:0] retry_n;
    assign mode = fault_config_one[mode_msb:mode_lsb];
    assign retry_n = fault_config_one[retry_msb:retry_lsb];

    // ==========================================
    // no-motor deglitch
    no_motor_deglitch #(.cyc_per_ms(cyc_per_ms)) u_deg (
        .clk(clk),
        .reset(reset),
        .sel(fault_config_one[deg_msb:deg_lsb]), // [RULE2]
        .raw(nm_s[1]),
        .filtered(no_motor)
    );

    // ==========================================
    // current-limit response state
    typedef enum logic [1:0] {
        st_drive = 2'b00,
        st_recirc = 2'b01
    } lim_state_t;
    lim_state_t state, next_state;
    logic [2:0] retries, next_retries;
    logic flt, next_flt;
    logic rpt, next_rpt;

    always_comb begin
        next_state = state;
        next_retries = retries;
        next_flt = flt;
        next_rpt = 1'b0;
        case (state)
            st_drive: begin
                next_flt = 1'b0;
                if (oc) begin
                    case (mode)
                        mode_next_pwm_flt, mode_next_pwm,
                        mode_retry_flt, mode_retry: begin
                            next_state = st_recirc; // [RULE3] [RULE5]
                            next_flt = (mode == mode_next_pwm_flt) ||
                                (mode == mode_retry_flt);
                            next_retries = 3'b000;
                        end
                        mode_below_flt, mode_below: begin
                            if (hs) begin // [RULE4]
                                next_state = st_recirc;
                                next_flt = (mode == mode_below_flt);
                            end
                        end
                        mode_report: next_rpt = 1'b1; // [RULE6]
                        default: ; // limiting off [RULE7]
                    endcase
                end
            end
            st_recirc: begin
                case (mode)
                    mode_next_pwm_flt, mode_next_pwm: begin
                        if (pwm_edge) next_state = st_drive; // [RULE3]
                    end
                    mode_below_flt, mode_below: begin
                        if (!vs) next_state = st_drive; // [RULE4]
                    end
                    mode_retry_flt, mode_retry: begin
                        if (pwm_edge) begin // [RULE5]
                            if (retries >= retry_n) next_state = st_drive;
                            else next_retries = retries + 3'b001;
                        end
                    end
                    default: next_state = st_drive; // [RULE7]
                endcase
                if (next_state == st_drive) next_flt = 1'b0;
            end
            default: next_state = st_drive;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= st_drive;
            retries <= 3'b000;
            flt <= 1'b0;
            rpt <= 1'b0;
        end else begin
            state <= next_state;
            retries <= next_retries;
            flt <= next_flt;
            rpt <= next_rpt;
        end
    end

    // ==========================================
    // outputs
    assign recirculate = (state == st_recirc);
    assign limit_report = rpt;
    assign fault_indicator_n = ~flt;
    // threshold amps = code / gain, left to the analog side [RULE8]
    assign lock_limit_code = fault_config_one[lock_msb:lock_lsb];
    assign lock_gain = sense_amp_gain;

    // ==========================================
    // assertions
    a_reset_zero: assert property ( // [RULE1]
        @(posedge clk)
        $fell(reset) |-> fault_config_one == fault_config_one_reset)
        else $error("register not zero after reset");
    a_report_only: assert property ( // [RULE6]
        @(posedge clk) disable iff (reset)
        (state == st_drive && oc && mode == mode_report) |=>
        (limit_report && !recirculate))
        else $error("report mode acted on bridge");
    a_disabled_idle: assert property ( // [RULE7]
        @(posedge clk) disable iff (reset)
        (state == st_drive && mode > 4'(mode_report)) |=> !recirculate)
        else $error("disabled mode recirculated");
    a_fault_pin_mode: assert property ( // [RULE3]
        @(posedge clk) disable iff (reset)
        (state == st_drive && oc && mode == mode_next_pwm) |=>
        (recirculate && fault_indicator_n))
        else $error("mode 1 drove fault pin");
    a_below_hold: assert property ( // [RULE4]
        @(posedge clk) disable iff (reset)
        (recirculate && mode == mode_below_flt && vs) |=>
        (recirculate && !fault_indicator_n))
        else $error("mode 2 left recirculation early");
    a_retry_fault: assert property ( // [RULE5]
        @(posedge clk) disable iff (reset)
        (state == st_drive && oc && mode == mode_retry_flt) |=>
        !fault_indicator_n ##0 recirculate)
        else $error("mode 4 missing fault");
    a_reserved_kept: assert property ( // [RULE9]
        @(posedge clk) disable iff (reset)
        (reg_write && reg_addr == fault_config_one_addr) |=>
        fault_config_one == $past(reg_wdata))
        else $error("write not stored whole");
    // the exported lock code may only move on a register write
    a_lock_code: assert property ( // [RULE8]
        @(posedge clk) disable iff (reset)
        !(reg_write && reg_addr == fault_config_one_addr) |=>
        $stable(lock_limit_code))
        else $error("lock code moved without a write");
endmodule : fault_config_current_limit

/* fault_config_current_limit_bench.sv */
// self-checking bench for the fault configuration block
`timescale 1ns/1ps
`define check_eq(name, exp, got) \
    begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); \
    end end
module fault_config_current_limit_bench;
    import fault_cfg_pkg::*;
    localparam int cpm = 4;
    logic clk, reset, oc, phase_hi, pwm, hs, nm_raw, reg_write;
    logic recirc, report, fault_n, no_motor;
    logic [3:0] gain, lock_code, lock_gain;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd, val;
    int mismatches, checked, cycles, reports, n, m;
    logic ef;
    int deg_ms[8] = '{1, 10, 25, 50, 100, 250, 500, 1000};
    // ==========================================
    // design, host and clock
    fault_config_current_limit #(.cyc_per_ms(cpm)) dut (.clk(clk),
        .reset(reset), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .overcurrent(oc),
        .phase_sense_voltage_high(phase_hi), .pwm_cycle_start(pwm),
        .high_side_mod(hs), .no_motor_raw(nm_raw), .sense_amp_gain(gain),
        .recirculate(recirc), .limit_report(report),
        .fault_indicator_n(fault_n), .no_motor(no_motor),
        .lock_limit_code(lock_code), .lock_gain(lock_gain));
    host_model host (.clk(clk), .reg_rdata(reg_rdata),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // cycle ceiling and report pulse counting, sampled off the launch edge
    always @(negedge clk) begin
        cycles++;
        if (report === 1'b1) reports++;
        if (cycles == 40000) begin
            mismatches++;
            close_out();
        end
    end
    // ==========================================
    // helpers
    function automatic logic exp_hold(int m, logic h);
        return m < 2 || m == 4 || m == 5 || ((m == 2 || m == 3) && h);
    endfunction : exp_hold
    function automatic logic exp_after(int m, logic h, int k, int r);
        return exp_hold(m, h) && (m == 2 || m == 3 || (m > 3 && k <= r));
    endfunction : exp_after
    task automatic wait_neg(int c);
        repeat (c) @(negedge clk);
    endtask : wait_neg
    task automatic pulse_pwm;
        pwm = 1'b1;
        wait_neg(3);
        pwm = 1'b0;
        wait_neg(4);
    endtask : pulse_pwm
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    // ==========================================
    // main sequence
    initial begin
        reset = 1'b1;
        {oc, pwm, hs, nm_raw, gain} = '0;
        phase_hi = 1'b1;
        void'($urandom(83447));
        wait_neg(20);
        reset = 1'b0;
        host.read_reg(fault_config_one_addr, rd);
        `check_eq("reset value", fault_config_one_reset, rd)
        host.write_reg(8'h94, 32'hffff_ffff);
        host.read_reg(8'h94, rd);
        `check_eq("unmapped read", 32'h0000_0000, rd)
        host.read_reg(fault_config_one_addr, rd);
        `check_eq("unmapped write", 32'h0000_0000, rd)
        // random words with reserved bits, back to back
        repeat (8) begin
            val = $urandom();
            gain = 4'($urandom());
            host.write_reg(fault_config_one_addr, ~val);
            host.write_reg(fault_config_one_addr, val);
            host.read_reg(fault_config_one_addr, rd);
            `check_eq("readback", val, rd)
            `check_eq("lock code", val[22:19], lock_code)
            `check_eq("lock gain", gain, lock_gain)
        end
        // every limit mode, random retry count and modulation side;
        // passes 16 and 17 repeat modes 2h/3h without high-side modulation
        for (int i = 0; i < 18; i++) begin
            m = (i < 16) ? i : i - 14;
            n = int'($urandom() % 8);
            hs = (m == 2 || m == 3) ? 1'(i < 16) : 1'($urandom());
            val = 32'h0000_0000;
            val[26:23] = 4'(m);
            val[10:8] = 3'(n);
            val[30] = 1'($urandom());
            host.write_reg(fault_config_one_addr, val);
            reports = 0;
            oc = 1'b1;
            wait_neg(6);
            `check_eq("hold", exp_hold(m, hs), recirc)
            ef = !(exp_hold(m, hs) && m % 2 == 0);
            `check_eq("fault", ef, fault_n)
            `check_eq("report", m == 6, reports > 0)
            oc = 1'b0;
            for (int k = 1; k <= 8; k++) begin
                pulse_pwm();
                `check_eq("pwm", exp_after(m, hs, k, n), recirc)
            end
            phase_hi = 1'b0;
            wait_neg(5);
            `check_eq("released", 1'b0, recirc)
            phase_hi = 1'b1;
        end
        // every deglitch code, short and full hold
        for (int s = 0; s < 8; s++) begin
            val = 32'h0000_0000;
            val[29:27] = 3'(s);
            host.write_reg(fault_config_one_addr, val);
            nm_raw = 1'b1;
            wait_neg(deg_ms[s] * cpm / 2);
            `check_eq("deglitch early", 1'b0, no_motor)
            wait_neg(deg_ms[s] * cpm / 2 + 8);
            `check_eq("deglitch late", 1'b1, no_motor)
            nm_raw = 1'b0;
            wait_neg(deg_ms[s] * cpm + 8);
        end
        close_out();
    end
endmodule : fault_config_current_limit_bench

/* host_model.sv */
// host model driving the register port of the fault configuration block
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // register port
    input wire logic [31:0] reg_rdata,
    output logic reg_write,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata
);
    // idle data shows a changing pattern, never the last word
    initial begin
        reg_write = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h5a5a_a5a5;
    end
    // one write pulse, launched at the falling edge
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_write = 1'b0;
        reg_wdata = ~d;
    endtask : write_reg
    // present address, take data one cycle later at the next falling edge
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
    endtask : read_reg
endmodule : host_model

/* no_motor_deglitch.sv */
// deglitch filter for the no-motor detect input
`timescale 1ns/1ps
module no_motor_deglitch
    import fault_cfg_pkg::*;
#(
    parameter int cyc_per_ms = cycles_per_ms
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic [2:0] sel,
    input wire logic raw,
    // result
    output logic filtered
);
    localparam int cnt_w = 36;

    // ==========================================
    // deglitch time lookup
    function automatic logic [cnt_w-1:0] deg_cycles(input logic [2:0] s);
        int ms;
        case (s)
            3'd0: ms = deg_ms_0;
            3'd1: ms = deg_ms_1;
            3'd2: ms = deg_ms_2;
            3'd3: ms = deg_ms_3;
            3'd4: ms = deg_ms_4;
            3'd5: ms = deg_ms_5;
            3'd6: ms = deg_ms_6;
            default: ms = deg_ms_7;
        endcase
        deg_cycles = cnt_w'(ms) * cnt_w'(cyc_per_ms);
    endfunction : deg_cycles

    logic [cnt_w-1:0] count;
    logic [cnt_w-1:0] next_count;
    logic next_filtered;

    // count while raw differs from filtered; adopt after the full time
    always_comb begin
        next_count = '0;
        next_filtered = filtered;
        if (raw != filtered) begin
            if (count + cnt_w'(1) >= deg_cycles(sel)) begin
                next_filtered = raw;
            end else begin
                next_count = count + cnt_w'(1);
            end
        end
    end

    // filter state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            filtered <= 1'b0;
        end else begin
            count <= next_count;
            filtered <= next_filtered;
        end
    end
endmodule : no_motor_deglitch
